// ### rtl/sw_entry_pkg.sv
/*
  Shared constants, types and helpers for the software instruction entry block:
  register offsets, status word and exception register field layout, entry
  address pieces, save order, state and rounding mode enumerations.
  Assumes a 32-bit core datapath and a byte-addressed Avalon-MM register window.
*/
package sw_entry_pkg;

  // Bus geometry
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FP_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_FP_EXC = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_FRAME_PTR = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_FRAME_LEN = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_PC = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_DSP_STAT = 5'h18;

  // Reset values
  localparam logic [31:0] FP_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [3:0] FRAME_LEN_RESET = 4'h0;

  // Control register: extended overflow exception disable
  localparam int CTRL_XOVF_DIS_BIT = 16;

  // Status word fields
  localparam int SR_COND_LSB = 0;
  localparam int SR_COND_MSB = 3;
  localparam int SR_S_BIT = 7;
  localparam int SR_FTE_LSB = 8;
  localparam int SR_FTE_MSB = 12;
  localparam int SR_FRM_LSB = 13;
  localparam int SR_FRM_MSB = 14;
  localparam int SR_ILC_LSB = 19;
  localparam logic [31:0] SR_M_MASK = 32'h0000_0010;
  localparam logic [31:0] SR_T_MASK = 32'h0000_0020;
  localparam logic [31:0] SR_L_MASK = 32'h0000_0040;
  localparam logic [31:0] SR_ILC_MASK = 32'h0018_0000;
  localparam logic [1:0] ILC_ENTRY = 2'h1;

  // Exception register layout and exception vector bits
  localparam int FER_ACCR_LSB = 0;
  localparam int FER_ACT_LSB = 8;
  localparam logic [31:0] FER_USED_MASK = 32'h0000_1F1F;
  localparam logic [4:0] EXC_INX_MASK = 5'h01;
  localparam logic [4:0] EXC_OVF_UNF_MASK = 5'h06;

  // Not-a-number encoding
  localparam int NAN_EXP_LSB = 19;
  localparam int NAN_EXP_MSB = 30;
  localparam int NAN_SIG_BIT = 0;

  // Entry address pieces
  localparam logic [22:0] ENTRY_ONES = 23'h7F_FFFF;
  localparam logic [3:0] ENTRY_LOW = 4'h0;
  localparam int OP_SEL_LSB = 8;
  localparam int OP_SEL_MSB = 11;

  // Frame handling
  localparam logic [3:0] FL_NEW = 4'h6;
  localparam logic [4:0] FL_ZERO_AS = 5'h10;

  // Save order, index of each word above the frame end
  localparam logic [2:0] SAVE_DEST = 3'h0;
  localparam logic [2:0] SAVE_HI = 3'h1;
  localparam logic [2:0] SAVE_LO = 3'h2;
  localparam logic [2:0] SAVE_PC = 3'h3;
  localparam logic [2:0] SAVE_SR = 3'h4;
  localparam logic [2:0] SAVE_COUNT = 3'h5;

  // Entry sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAVE = 2'b01,
    ST_COMMIT = 2'b10
  } swi_state_t;

  // Rounding mode encoding
  typedef enum logic [1:0] {
    RND_NEAREST = 2'b00,
    RND_ZERO = 2'b01,
    RND_MINUS_INF = 2'b10,
    RND_PLUS_INF = 2'b11
  } rnd_mode_t;

  // Classifies a word holding the exponent as not-a-number
  function automatic logic is_nan(input logic [31:0] word);
    is_nan = &word[NAN_EXP_MSB:NAN_EXP_LSB];
  endfunction : is_nan

  // Merges write data into a register under the byte enables
  function automatic logic [31:0] merge_be(input logic [31:0] old_val, input logic [31:0] new_val,
                                           input logic [3:0] be);
    merge_be = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge_be[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
  endfunction : merge_be

endpackage : sw_entry_pkg

// ### rtl/fp_flag_update.sv
/*
  Floating-point exception register: accrued and actual flags, updated by
  exception events from the emulation path and by software writes.
  Assumes events and writes come from logic on mclk; trap enables are a level.
*/
`timescale 1ns/1ps
module fp_flag_update import sw_entry_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sw_we,
  input wire logic [31:0] sw_wdata,
  input wire logic exc_valid,
  input wire logic [4:0] exc_flags,
  input wire logic [4:0] trap_en,
  output logic [31:0] fer_value,
  output logic trap_pulse
);

  logic [31:0] fer_ff; // Exception register
  logic [31:0] nxt_fer_ff;
  logic trap_ff; // Trap taken, destination kept
  logic nxt_trap_ff;

  // Enabled exceptions, before precedence
  wire [4:0] raw_trap = exc_valid ? (exc_flags & trap_en) : 5'h00;
  // Overflow or underflow trap present
  wire ovf_unf_trap = |(raw_trap & EXC_OVF_UNF_MASK);
  // Inexact trap loses to overflow or underflow
  wire [4:0] trap_set = ovf_unf_trap ? (raw_trap & ~EXC_INX_MASK) : raw_trap;
  // Accrued bits for disabled exceptions, plus inexact when overruled
  wire [4:0] accr_set = exc_valid ? ((exc_flags & ~trap_en) |
                        (ovf_unf_trap ? (exc_flags & EXC_INX_MASK) : 5'h00)) : 5'h00;
  // Software write first, hardware event layered on top
  wire [31:0] base_fer = sw_we ? (sw_wdata & FER_USED_MASK) : fer_ff;
  wire [4:0] base_accr = base_fer[FER_ACCR_LSB +: 5];
  wire [4:0] base_act = base_fer[FER_ACT_LSB +: 5];
  // Trap replaces actual flags, others cleared
  wire [4:0] nxt_act = (|trap_set) ? trap_set : base_act;
  wire [4:0] nxt_accr = base_accr | accr_set;

  assign nxt_fer_ff = (32'(nxt_act) << FER_ACT_LSB) | (32'(nxt_accr) << FER_ACCR_LSB);
  assign nxt_trap_ff = |trap_set;

  // Flag storage
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fer_ff <= 32'h0000_0000;
      trap_ff <= 1'b0;
    end else begin
      fer_ff <= nxt_fer_ff;
      trap_ff <= nxt_trap_ff;
    end
  end

  assign fer_value = fer_ff;
  assign trap_pulse = trap_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  AST_FER_RSVD: assert property ((fer_ff & ~FER_USED_MASK) == 32'h0000_0000)
    else $error("Reserved exception register bits not zero");
  AST_TRAP_ACTUAL: assert property (exc_valid && (exc_flags & trap_en & ~EXC_OVF_UNF_MASK & ~EXC_INX_MASK) != 5'h00
    |=> trap_ff && fer_ff[FER_ACT_LSB +: 5] == $past(exc_flags & trap_en & ~EXC_INX_MASK))
    else $error("Actual flags not set from enabled exception");
  AST_INX_ACCRUED: assert property (exc_valid && (exc_flags & trap_en & EXC_OVF_UNF_MASK) != 5'h00
    && (exc_flags & EXC_INX_MASK) != 5'h00
    |=> fer_ff[FER_ACCR_LSB] && !fer_ff[FER_ACT_LSB])
    else $error("Inexact not accrued or trapped over overflow");

endmodule : fp_flag_update

// ### rtl/software_instruction_entry.sv
/*
  Software instruction entry, DSP result interlock and floating-point flag
  support for the core. Holds the Avalon-MM register window, the entry
  sequencer that writes five words into the local register stack, the
  result interlock for the multiply-accumulate unit and the NaN classifier.
  Assumes pipeline and MAC signals are on mclk and that software runs a frame
  setting instruction before the next entry or before unlocking interrupts.
*/
`timescale 1ns/1ps
module software_instruction_entry import sw_entry_pkg::*; #(
  parameter int FP_W = 7
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic dsp_issue,
  input wire logic dsp_double,
  input wire logic mac_done_low,
  input wire logic mac_done_high,
  input wire logic mac_overflow,
  input wire logic instr_valid,
  input wire logic instr_is_dsp,
  input wire logic instr_uses_low,
  input wire logic instr_uses_high,
  output logic core_stall,
  output logic ext_overflow_trap,
  input wire logic ext_trap_taken,
  input wire logic swi_req,
  input wire logic [15:0] swi_opcode,
  input wire logic [31:0] swi_dest_addr,
  input wire logic [31:0] swi_src_high,
  input wire logic [31:0] swi_src_low,
  input wire logic [31:0] swi_ret_pc,
  output logic swi_ack,
  output logic fetch_hold,
  output logic rf_we,
  output logic [FP_W-1:0] rf_addr,
  output logic [31:0] rf_wdata,
  output logic pc_load,
  output logic [31:0] pc_value,
  input wire logic fp_exc_valid,
  input wire logic [4:0] fp_exc_flags,
  output logic fp_trap,
  output rnd_mode_t rounding_mode_field,
  output logic [4:0] fp_trap_enables,
  input wire logic nan_check_valid,
  input wire logic [31:0] nan_check_word,
  output logic nan_found,
  output logic nan_signalling
);

  // Register bus state
  logic bus_ack_ff; // Second cycle of an access
  logic [31:0] readdata_ff; // Read data
  logic [31:0] nxt_readdata_ff;
  // Software visible registers
  logic [31:0] fp_ctrl_ff; // fp_control_reg
  logic [31:0] nxt_fp_ctrl_ff;
  logic [31:0] status_ff; // status_word
  logic [31:0] nxt_status_ff;
  logic [FP_W-1:0] frame_pointer_ff;
  logic [FP_W-1:0] nxt_frame_pointer_ff;
  logic [3:0] frame_length_ff;
  logic [3:0] nxt_frame_length_ff;
  logic [31:0] pc_ff; // Program counter
  logic [31:0] nxt_pc_ff;
  logic [31:0] fer_value; // fp_exception_reg
  // Interlock state
  logic pend_low_ff; // dsp_result_low outstanding
  logic nxt_pend_low_ff;
  logic pend_high_ff; // dsp_result_high outstanding
  logic nxt_pend_high_ff;
  logic xovf_ff; // Extended overflow trap pending
  logic nxt_xovf_ff;
  // Entry sequencer
  swi_state_t state_ff;
  swi_state_t nxt_state_ff;
  logic [2:0] save_idx_ff; // Next word to present
  logic [2:0] nxt_save_idx_ff;
  logic rf_we_ff;
  logic nxt_rf_we_ff;
  logic [FP_W-1:0] rf_addr_ff;
  logic [FP_W-1:0] nxt_rf_addr_ff;
  logic [31:0] rf_wdata_ff;
  logic [31:0] nxt_rf_wdata_ff;
  logic [31:0] cap_hi_ff; // Captured operands for the saves
  logic [31:0] cap_lo_ff;
  logic [31:0] cap_pc_ff;
  logic [31:0] cap_sr_ff;
  logic [3:0] cap_op_ff; // Opcode entry selector
  // NaN classifier
  logic nan_found_ff;
  logic nan_sig_ff;

  // Avalon handshake: wait one cycle, accept on the second
  wire bus_req = avs_read | avs_write;
  wire wr_fire = avs_write & bus_ack_ff;
  wire rd_take = avs_read & ~bus_ack_ff;
  wire sel_ctrl = (avs_address == OFS_FP_CTRL);
  wire sel_status = (avs_address == OFS_STATUS);
  wire sel_fer = (avs_address == OFS_FP_EXC);
  wire sel_fp = (avs_address == OFS_FRAME_PTR);
  wire sel_fl = (avs_address == OFS_FRAME_LEN);
  wire sel_pc = (avs_address == OFS_PC);
  wire sel_dsp = (avs_address == OFS_DSP_STAT);
  // Read mux, unmapped reads zero
  wire [31:0] rd_mux = sel_ctrl ? fp_ctrl_ff :
                       sel_status ? status_ff :
                       sel_fer ? fer_value :
                       sel_fp ? 32'(frame_pointer_ff) :
                       sel_fl ? 32'(frame_length_ff) :
                       sel_pc ? pc_ff :
                       sel_dsp ? {29'h0000_0000, xovf_ff, pend_high_ff, pend_low_ff} :
                       32'h0000_0000;
  wire [31:0] status_wr = merge_be(status_ff, avs_writedata, avs_byteenable);
  wire fer_we = wr_fire & sel_fer;

  assign avs_waitrequest = bus_req & ~bus_ack_ff;
  assign nxt_readdata_ff = rd_take ? rd_mux : readdata_ff;

  // Bus handshake and read data
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bus_ack_ff <= 1'b0;
      readdata_ff <= 32'h0000_0000;
    end else begin
      bus_ack_ff <= bus_req & ~bus_ack_ff;
      readdata_ff <= nxt_readdata_ff;
    end
  end

  // Extended overflow only when disable bit is clear
  wire xovf_set = mac_overflow & ~fp_ctrl_ff[CTRL_XOVF_DIS_BIT];
  // Pending independent of issue; set wins over take
  assign nxt_xovf_ff = xovf_set | (xovf_ff & ~ext_trap_taken);
  // New issue marks low result outstanding, a double issue also the high one; wins over completion
  assign nxt_pend_low_ff = dsp_issue ? 1'b1 : (mac_done_low ? 1'b0 : pend_low_ff);
  assign nxt_pend_high_ff = (dsp_issue & dsp_double) ? 1'b1 : (mac_done_high ? 1'b0 : pend_high_ff);
  // Only non-DSP readers of outstanding results wait; DSP issue never stalls
  assign core_stall = instr_valid & ~instr_is_dsp &
                      ((instr_uses_low & pend_low_ff) | (instr_uses_high & pend_high_ff));

  // Interlock flags
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pend_low_ff <= 1'b0;
      pend_high_ff <= 1'b0;
      xovf_ff <= 1'b0;
    end else begin
      pend_low_ff <= nxt_pend_low_ff;
      pend_high_ff <= nxt_pend_high_ff;
      xovf_ff <= nxt_xovf_ff;
    end
  end

  // Effective frame length, zero meaning sixteen
  wire [4:0] fl_eff = (frame_length_ff == 4'h0) ? FL_ZERO_AS : {1'b0, frame_length_ff};
  wire [FP_W-1:0] save_base = FP_W'(frame_pointer_ff + fl_eff);
  wire swi_start = (state_ff == ST_IDLE) & swi_req;
  wire commit = (state_ff == ST_SAVE) & (save_idx_ff == SAVE_COUNT);
  // Saved status word with length code one
  wire [31:0] sr_saved = (status_ff & ~SR_ILC_MASK) | (32'(ILC_ENTRY) << SR_ILC_LSB);
  // Saved return address with supervisor flag in bit zero
  wire [31:0] pc_saved = {swi_ret_pc[31:1], status_ff[SR_S_BIT]};
  // Word order above the frame end
  wire [31:0] save_word = (save_idx_ff == SAVE_HI) ? cap_hi_ff :
                          (save_idx_ff == SAVE_LO) ? cap_lo_ff :
                          (save_idx_ff == SAVE_PC) ? cap_pc_ff :
                          cap_sr_ff;
  // Entry address from the opcode selector
  wire [31:0] entry_addr = {ENTRY_ONES, 1'b0, cap_op_ff, ENTRY_LOW};
  // Mode flags on entry, condition flags untouched
  wire [31:0] sr_entry = (status_ff & ~(SR_M_MASK | SR_T_MASK)) | SR_L_MASK;

  // Sequencer next state
  always_comb begin
    nxt_state_ff = state_ff;
    nxt_save_idx_ff = save_idx_ff;
    nxt_rf_we_ff = rf_we_ff;
    nxt_rf_addr_ff = rf_addr_ff;
    nxt_rf_wdata_ff = rf_wdata_ff;
    case (state_ff)
      ST_IDLE: begin
        // First save is the destination stack address
        if (swi_req) begin
          nxt_state_ff = ST_SAVE;
          nxt_rf_we_ff = 1'b1;
          nxt_rf_addr_ff = save_base;
          nxt_rf_wdata_ff = swi_dest_addr;
          nxt_save_idx_ff = SAVE_HI;
        end
      end
      ST_SAVE: begin
        // Walk upward through the remaining words
        if (save_idx_ff == SAVE_COUNT) begin
          nxt_rf_we_ff = 1'b0;
          nxt_state_ff = ST_COMMIT;
        end else begin
          nxt_rf_addr_ff = FP_W'(rf_addr_ff + 1'b1);
          nxt_rf_wdata_ff = save_word;
          nxt_save_idx_ff = 3'(save_idx_ff + 1'b1);
        end
      end
      ST_COMMIT: begin
        // Entry address presented, fetch resumes
        nxt_state_ff = ST_IDLE;
        nxt_save_idx_ff = SAVE_DEST;
      end
      default: begin
        nxt_state_ff = ST_IDLE;
        nxt_rf_we_ff = 1'b0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      save_idx_ff <= SAVE_DEST;
      rf_we_ff <= 1'b0;
      rf_addr_ff <= '0;
      rf_wdata_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state_ff;
      save_idx_ff <= nxt_save_idx_ff;
      rf_we_ff <= nxt_rf_we_ff;
      rf_addr_ff <= nxt_rf_addr_ff;
      rf_wdata_ff <= nxt_rf_wdata_ff;
    end
  end

  // Operand capture at the start of an entry
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cap_hi_ff <= 32'h0000_0000;
      cap_lo_ff <= 32'h0000_0000;
      cap_pc_ff <= 32'h0000_0000;
      cap_sr_ff <= 32'h0000_0000;
      cap_op_ff <= 4'h0;
    end else if (swi_start) begin
      cap_hi_ff <= swi_src_high;
      cap_lo_ff <= swi_src_low;
      cap_pc_ff <= pc_saved;
      cap_sr_ff <= sr_saved;
      cap_op_ff <= swi_opcode[OP_SEL_MSB:OP_SEL_LSB];
    end
  end

  // Register next values; entry commit wins over software writes
  assign nxt_fp_ctrl_ff = (wr_fire & sel_ctrl) ? merge_be(fp_ctrl_ff, avs_writedata, avs_byteenable) : fp_ctrl_ff;
  assign nxt_status_ff = commit ? sr_entry : ((wr_fire & sel_status) ? status_wr : status_ff);
  assign nxt_frame_pointer_ff = commit ? save_base :
                                ((wr_fire & sel_fp & avs_byteenable[0]) ? avs_writedata[FP_W-1:0] :
                                frame_pointer_ff);
  assign nxt_frame_length_ff = commit ? FL_NEW :
                               ((wr_fire & sel_fl & avs_byteenable[0]) ? avs_writedata[3:0] :
                               frame_length_ff);
  assign nxt_pc_ff = commit ? entry_addr : pc_ff;

  // Software visible registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fp_ctrl_ff <= FP_CTRL_RESET;
      status_ff <= STATUS_RESET;
      frame_pointer_ff <= '0;
      frame_length_ff <= FRAME_LEN_RESET;
      pc_ff <= PC_RESET;
    end else begin
      fp_ctrl_ff <= nxt_fp_ctrl_ff;
      status_ff <= nxt_status_ff;
      frame_pointer_ff <= nxt_frame_pointer_ff;
      frame_length_ff <= nxt_frame_length_ff;
      pc_ff <= nxt_pc_ff;
    end
  end

  // Exception register and trap decision
  fp_flag_update u_flags (
    .mclk(mclk),
    .reset_n(reset_n),
    .sw_we(fer_we),
    .sw_wdata(avs_writedata),
    .exc_valid(fp_exc_valid),
    .exc_flags(fp_exc_flags),
    .trap_en(status_ff[SR_FTE_MSB:SR_FTE_LSB]),
    .fer_value(fer_value),
    .trap_pulse(fp_trap)
  );

  // NaN classification of an exponent-holding word
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      nan_found_ff <= 1'b0;
      nan_sig_ff <= 1'b0;
    end else if (nan_check_valid) begin
      nan_found_ff <= is_nan(nan_check_word);
      nan_sig_ff <= is_nan(nan_check_word) & nan_check_word[NAN_SIG_BIT];
    end
  end

  // Outputs
  assign avs_readdata = readdata_ff;
  assign ext_overflow_trap = xovf_ff;
  assign swi_ack = swi_start;
  assign fetch_hold = (state_ff != ST_IDLE);
  assign rf_we = rf_we_ff;
  assign rf_addr = rf_addr_ff;
  assign rf_wdata = rf_wdata_ff;
  assign pc_load = (state_ff == ST_COMMIT);
  assign pc_value = pc_ff;
  assign rounding_mode_field = rnd_mode_t'(status_ff[SR_FRM_MSB:SR_FRM_LSB]);
  assign fp_trap_enables = status_ff[SR_FTE_MSB:SR_FTE_LSB];
  assign nan_found = nan_found_ff;
  assign nan_signalling = nan_sig_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence seq_saves;
    rf_we [*5];
  endsequence

  AST_XOVF_GATE: assert property ($rose(xovf_ff) |-> $past(mac_overflow) && !$past(fp_ctrl_ff[CTRL_XOVF_DIS_BIT]))
    else $error("Extended overflow raised while disabled");
  AST_XOVF_HOLD: assert property (xovf_ff && !ext_trap_taken |=> xovf_ff)
    else $error("Overflow trap lost before taken");
  AST_DSP_NOSTALL: assert property (instr_valid && instr_is_dsp |-> !core_stall)
    else $error("DSP operation stalled at issue");
  AST_STALL_READER: assert property (dsp_issue ##1 (instr_valid && !instr_is_dsp && instr_uses_low && !mac_done_low)
    |-> core_stall)
    else $error("Reader of pending result not stalled");
  AST_ENTRY_SEQ: assert property (swi_ack |=> seq_saves ##1
    (pc_load && pc_value == {ENTRY_ONES, 1'b0, $past(swi_opcode[OP_SEL_MSB:OP_SEL_LSB], 6), ENTRY_LOW}))
    else $error("Entry sequence or entry address wrong");
  AST_FIRST_SAVE: assert property (swi_ack |=> rf_we && rf_wdata == $past(swi_dest_addr)
    && rf_addr == $past(save_base) ##1 rf_wdata == $past(swi_src_high, 2))
    else $error("Save order or base wrong");
  AST_FL_ZERO: assert property (commit && frame_length_ff == 4'h0
    |=> frame_pointer_ff == FP_W'($past(frame_pointer_ff) + FL_ZERO_AS))
    else $error("Zero frame length not treated as sixteen");
  AST_ILC: assert property (swi_ack |-> ##5 (rf_we && (rf_wdata & SR_ILC_MASK) == (32'(ILC_ENTRY) << SR_ILC_LSB)))
    else $error("Saved length code not one");
  AST_NEW_FRAME: assert property (pc_load |-> frame_length_ff == FL_NEW && !rf_we)
    else $error("Frame not set before entry fetch");
  AST_ENTRY_FLAGS: assert property (commit |=> (status_ff & (SR_M_MASK | SR_T_MASK)) == 32'h0000_0000
    && (status_ff & SR_L_MASK) != 32'h0000_0000
    && status_ff[SR_COND_MSB:SR_COND_LSB] == $past(status_ff[SR_COND_MSB:SR_COND_LSB]))
    else $error("Entry flags wrong");
  AST_NAN: assert property (nan_check_valid |=> nan_found == $past(&nan_check_word[NAN_EXP_MSB:NAN_EXP_LSB])
    && nan_signalling == ($past(&nan_check_word[NAN_EXP_MSB:NAN_EXP_LSB]) && $past(nan_check_word[0])))
    else $error("NaN classification wrong");

endmodule : software_instruction_entry

// ### bench/software_instruction_entry_tb.sv
/* Self-checking bench for the entry block: registers, entry sequence, DSP interlock, FP flags, NaN.
   Assumes the package and design compile first; the bench drives every port itself. */
`timescale 1ns/1ps
module software_instruction_entry_tb import sw_entry_pkg::*;;
  logic mclk = 0, reset_n = 0, avs_read = 0, avs_write = 0, dsp_issue = 0, dsp_double = 0;
  logic mac_done_low = 0, mac_done_high = 0, mac_overflow = 0, instr_valid = 0, instr_is_dsp = 0;
  logic instr_uses_low = 0, instr_uses_high = 0, ext_trap_taken = 0, swi_req = 0;
  logic fp_exc_valid = 0, nan_check_valid = 0;
  logic [4:0] avs_address = '0, fp_exc_flags = '0, fp_trap_enables;
  logic [3:0] avs_byteenable = 4'hF;
  logic [15:0] swi_opcode = 16'h3A55;
  logic [31:0] avs_writedata = '0, swi_dest_addr = 32'hD0, swi_src_high = 32'hAAAA_0001;
  logic [31:0] swi_src_low = 32'h5555_0002, swi_ret_pc = 32'h1234, nan_check_word = '0;
  logic [31:0] avs_readdata, rf_wdata, pc_value, q;
  logic avs_waitrequest, core_stall, ext_overflow_trap, swi_ack, fetch_hold, rf_we, pc_load;
  logic fp_trap, nan_found, nan_signalling;
  logic [6:0] rf_addr;
  rnd_mode_t rounding_mode_field;
  int n_fail = 0, n_compared = 0;
  // Saved words, NaN words and expected {found, signalling}
  logic [31:0] ev [5] = '{32'hD0, 32'hAAAA_0001, 32'h5555_0002, 32'h1235, 32'h0008_75BA};
  logic [31:0] nw [4] = '{32'h7FF8_0000, 32'h7FF8_0001, 32'h7FF7_FFFF, 32'hFFF8_0000};
  logic [1:0] ne [4] = '{2'h2, 2'h3, 2'h0, 2'h2};
  software_instruction_entry dut_u (.*);
  // Free-running 50 MHz clock
  always #10 mclk = ~mclk;
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One Avalon transfer, held until waitrequest low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a; avs_writedata <= d; avs_write <= w; avs_read <= !w;
    // Waitrequest is sampled at the rising edge; accept and read data share that edge
    do begin @(posedge mclk); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      $display("Error bus waitrequest expected 0 seen %b", avs_waitrequest);
    end
    q = avs_readdata;
    avs_read <= 0; avs_write <= 0;
  endtask : bus
  // Reset values, unmapped read, rounding and enable fields
  task automatic t_regs;
    for (int a = 0; a < 32; a += 4) begin bus(0, a[4:0], '0); chk("reset", '0, q); end
    for (int m = 0; m < 4; m++) begin
      bus(1, 5'h04, {17'h0, m[1:0], 13'h15BA});
      repeat (2) @(negedge mclk);
      chk("rounding", m, {30'h0, rounding_mode_field});
      chk("enables", 32'h15, {27'h0, fp_trap_enables});
    end
  endtask : t_regs
  // Entry with frame length zero, status 0x75BA
  task automatic t_entry;
    bus(1, 5'h0C, 32'h10);
    @(posedge mclk) swi_req <= 1;
    @(negedge mclk) chk("ack", 1, swi_ack);
    @(posedge mclk) swi_req <= 0;
    for (int i = 0; i < 5; i++) begin
      @(negedge mclk) chk("rf_we", 1, rf_we);
      chk("fetch_hold", 1, fetch_hold);
      chk("rf_addr", 32'h20 + i, {25'h0, rf_addr});
      chk("rf_wdata", ev[i], rf_wdata);
    end
    @(negedge mclk) chk("pc_load", 1, pc_load);
    chk("pc", 32'hFFFF_FEA0, pc_value);
    @(negedge mclk) chk("hold off", 0, fetch_hold);
    bus(0, 5'h0C, '0); chk("fp", 32'h20, q);
    bus(0, 5'h10, '0); chk("fl", 32'h6, q);
    bus(0, 5'h04, '0); chk("status", 32'h75CA, q);
  endtask : t_entry
  // Result interlock and deferred overflow
  task automatic t_dsp;
    @(posedge mclk) dsp_issue <= 1;
    @(posedge mclk) dsp_issue <= 0; instr_valid <= 1; instr_uses_low <= 1; mac_overflow <= 1;
    @(negedge mclk) chk("stall low", 1, core_stall);
    @(posedge mclk) instr_is_dsp <= 1; mac_overflow <= 0; dsp_issue <= 1; dsp_double <= 1;
    @(negedge mclk) chk("dsp no stall", 0, core_stall);
    chk("ovf", 1, ext_overflow_trap);
    @(posedge mclk) instr_is_dsp <= 0; instr_uses_low <= 0; instr_uses_high <= 1; dsp_issue <= 0; dsp_double <= 0;
    @(negedge mclk) chk("stall high", 1, core_stall);
    @(posedge mclk) instr_uses_high <= 0; instr_uses_low <= 1; mac_done_low <= 1; mac_done_high <= 1;
    ext_trap_taken <= 1;
    @(negedge mclk) chk("stall done", 1, core_stall);
    @(posedge mclk) mac_done_low <= 0; mac_done_high <= 0; ext_trap_taken <= 0;
    @(negedge mclk) chk("released", 0, core_stall);
    chk("trap taken", 0, ext_overflow_trap);
    @(posedge mclk) instr_valid <= 0; instr_uses_low <= 0;
    bus(0, 5'h18, '0); chk("dsp stat", 0, q);
    bus(1, 5'h00, 32'h0001_0000);
    @(posedge mclk) mac_overflow <= 1;
    @(posedge mclk) mac_overflow <= 0;
    @(negedge mclk) chk("ovf off", 0, ext_overflow_trap);
  endtask : t_dsp
  // Exception flags: reserved bits, priority, accrual
  task automatic t_fp;
    bus(1, 5'h08, '1); bus(0, 5'h08, '0); chk("fer mask", 32'h1F1F, q);
    bus(1, 5'h08, '0); bus(1, 5'h04, 32'h400);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk) fp_exc_valid <= 1; fp_exc_flags <= k ? 5'h10 : 5'h05;
      @(posedge mclk) fp_exc_valid <= 0;
      @(negedge mclk) chk("fp_trap", k ? 0 : 1, fp_trap);
      bus(0, 5'h08, '0); chk("fer", k ? 32'h411 : 32'h401, q);
    end
  endtask : t_fp
  // NaN classification table
  task automatic t_nan;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk) nan_check_valid <= 1; nan_check_word <= nw[i];
      @(posedge mclk) nan_check_valid <= 0;
      @(negedge mclk) chk("nan", ne[i], {30'h0, nan_found, nan_signalling});
    end
  endtask : t_nan
  // Verdict and end of run
  task automatic stop_test;
    $display("Compared %0d, errors %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // Main sequence after five reset cycles
  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1;
    t_regs; t_entry; t_dsp; t_fp; t_nan;
    stop_test;
  end
  // Watchdog against a hang
  initial begin
    #200000;
    n_fail++;
    stop_test;
  end
endmodule : software_instruction_entry_tb
